// ### core/evpu_pkg.sv
// Constants and types shared by the exception vector priority unit
package evpu_pkg;
  localparam logic [5:0]  IDX_TEST_CTRL   = 6'h15;
  localparam logic [5:0]  IDX_TEST_WINDOW = 6'h16;
  localparam logic [5:0]  IDX_PROMO_SEL   = 6'h1F;
  localparam logic [7:0]  ADDR_TEST_CTRL   = {IDX_TEST_CTRL, 2'b00};
  localparam logic [7:0]  ADDR_TEST_WINDOW = {IDX_TEST_WINDOW, 2'b00};
  localparam logic [7:0]  ADDR_PROMO_SEL   = {IDX_PROMO_SEL, 2'b00};

  localparam int          CTRL_OVR_BIT    = 4;
  localparam logic [7:0]  CTRL_RST        = 8'h00;
  localparam logic [7:0]  PROMO_RST       = 8'hF2;
  localparam logic [7:0]  PROMO_MAX       = 8'hF2;
  localparam logic [3:0]  GROUP_TOP       = 4'hF;
  localparam logic [7:0]  GROUP_TOP_MASK  = 8'h07;

  localparam logic [6:0]  IDX_IRQ         = 7'h79;
  localparam int          IDX_HIGH_PRIORITY_PIN_REQUEST        = 122;
  localparam int          LIVE_BITS       = 123;

  localparam logic [15:0] VEC_BASE        = 16'hFF00;
  localparam logic [15:0] VEC_SYS_RESET   = 16'hFFFE;
  localparam logic [15:0] VEC_CLK_MON     = 16'hFFFC;
  localparam logic [15:0] VEC_WATCHDOG    = 16'hFFFA;
  localparam logic [15:0] VEC_TRAP        = 16'hFFF8;
  localparam logic [15:0] VEC_SWI         = 16'hFFF6;
  localparam logic [15:0] VEC_HIGH_PRIORITY_PIN_REQUEST        = 16'hFFF4;

  typedef struct packed {
    logic sys_reset;
    logic clk_mon_reset;
    logic watchdog_reset;
    logic trap;
    logic software_interrupt;
    logic high_priority_pin_request;
  } evpu_exc_t;

  typedef struct packed {
    logic       special_mode;
    logic       i_mask;
    logic       x_mask;
  } evpu_cpu_t;
endpackage

// ### core/evpu_prio_pick.sv
// Highest-index finder for the maskable request vector
`timescale 1ns/10ps
`default_nettype none
module evpu_prio_pick #(
  parameter int WIDTH = 122,
  parameter int IW    = 7
) (
  input  wire logic [WIDTH-1:0] i_req,
  output logic                  o_any,
  output logic      [IW-1:0]    o_idx
);
  always_comb begin
    o_any = 1'b0;
    o_idx = '0;
    for (int k = 0; k < WIDTH; k++) begin
      if (i_req[k]) begin
        o_any = 1'b1;
        o_idx = IW'(k);
      end
    end
  end
endmodule
`default_nettype wire

// ### core/evpu_top.sv
// Exception vector priority unit with test and promotion registers
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Override bit writable: special mode, both masks
// - Override feeds decoder from test registers
// - Pending requests kept when override sets
// - Group select chooses test register, anytime
// - Test reads: live/stored in special, else zero
// - Test writes: special, override, I mask
// - Each test bit forces one vector
// - One test register per eight vectors
// - Top group: only bits 2..0 usable
// - Unimplemented group: writes ignored, reads zero
// - Promotion register writable only with I mask
// - Invalid promotion value falls back to IRQ
// - Promoted request wins among maskable sources
// - Tick interrupt takes the vacated slot
// - Priority resolved when CPU requests vector
// - Vanished request gives last valid vector
// - Never pending gives software interrupt vector
// - Reset requests map to their vectors
// - Fixed priority order, resets down to FF00
// - Wake on enabled interrupt or pin request
module evpu_top #(
  parameter int         I_VECTORS = 122,
  parameter logic [6:0] RTI_IDX   = 7'h78
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [7:0]           i_paddr,
  input  wire logic [31:0]          i_pwdata,
  output logic      [31:0]          o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  input  wire logic [121:0]         i_irq_lines,
  input  wire evpu_pkg::evpu_exc_t  i_exc,
  input  wire evpu_pkg::evpu_cpu_t  i_cpu,
  input  wire logic                 i_vec_req,
  output logic      [15:0]          o_vec_addr,
  output logic                      o_int_pending,
  output logic                      o_wakeup
);
  logic                              override_r;
  logic [3:0]                        group_r;
  logic [6:0]                        promo_r;
  logic [evpu_pkg::LIVE_BITS-1:0]    store_r;
  logic [15:0]                       last_vec_r;
  logic                              seen_r;
  logic [evpu_pkg::LIVE_BITS-1:0]    live_w;
  logic [evpu_pkg::LIVE_BITS-1:0]    src_w;
  logic [121:0]                      mask_w;
  logic [121:0]                      perm_w;
  logic                              pick_any_w;
  logic [6:0]                        pick_idx_w;
  logic [6:0]                        promo_idx_w;
  logic [6:0]                        win_idx_w;
  logic                              any_w;
  logic [15:0]                       cur_vec_w;
  logic                              setup_w;
  logic                              wr_w;
  logic                              mapped_w;
  logic                              ovr_ok_w;
  logic                              test_ok_w;
  logic                              grp_impl_w;
  logic [7:0]                        grp_mask_w;
  logic [7:0]                        grp_live_w;
  logic [7:0]                        grp_store_w;
  logic [7:0]                        rd_w;

  function automatic logic [15:0] vec_of(input logic [6:0] idx);
    vec_of = evpu_pkg::VEC_BASE | {8'h00, idx, 1'b0};
  endfunction

  function automatic logic [7:0] group_bits(input logic [evpu_pkg::LIVE_BITS-1:0] v, input logic [3:0] g);
    logic [7:0] b;
    b = 8'h00;
    for (int j = 0; j < 8; j++) begin
      if ((int'(g) * 8 + j) < evpu_pkg::LIVE_BITS) begin
        b[j] = v[int'(g) * 8 + j];
      end
    end
    group_bits = b;
  endfunction

  // APB access phase control
  assign setup_w  = i_psel && i_penable && !o_pready;
  assign wr_w     = i_psel && i_penable && o_pready && i_pwrite;
  assign mapped_w = (i_paddr == evpu_pkg::ADDR_TEST_CTRL) || (i_paddr == evpu_pkg::ADDR_TEST_WINDOW) ||
                    (i_paddr == evpu_pkg::ADDR_PROMO_SEL);
  assign live_w   = {i_exc.high_priority_pin_request, i_irq_lines};

  assign ovr_ok_w  = i_cpu.special_mode && i_cpu.i_mask && i_cpu.x_mask;
  assign test_ok_w = i_cpu.special_mode && override_r && i_cpu.i_mask;

  always_comb begin
    grp_impl_w = (int'(group_r) * 8 < I_VECTORS) || (group_r == evpu_pkg::GROUP_TOP);
    grp_mask_w = (group_r == evpu_pkg::GROUP_TOP) ? evpu_pkg::GROUP_TOP_MASK : 8'hFF;
    if (!grp_impl_w) begin
      grp_mask_w = 8'h00;
    end
    grp_live_w  = group_bits(live_w, group_r) & grp_mask_w;
    grp_store_w = group_bits(store_r, group_r) & grp_mask_w;
  end

  always_comb begin
    rd_w = 8'h00;
    if (i_paddr == evpu_pkg::ADDR_TEST_CTRL) begin
      rd_w = {3'b000, override_r, group_r};
    end else if (i_paddr == evpu_pkg::ADDR_TEST_WINDOW) begin
      if (i_cpu.special_mode) begin
        rd_w = override_r ? grp_store_w : grp_live_w;
      end
    end else if (i_paddr == evpu_pkg::ADDR_PROMO_SEL) begin
      rd_w = {promo_r, 1'b0};
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= setup_w;
      o_pslverr <= setup_w && !mapped_w;
      if (setup_w && !i_pwrite) begin
        o_prdata <= {24'h00_0000, rd_w};
      end else if (setup_w) begin
        o_prdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      group_r    <= evpu_pkg::CTRL_RST[3:0];
      override_r <= evpu_pkg::CTRL_RST[evpu_pkg::CTRL_OVR_BIT];
    end else if (wr_w && i_paddr == evpu_pkg::ADDR_TEST_CTRL) begin
      group_r <= i_pwdata[3:0];
      if (ovr_ok_w) begin
        override_r <= i_pwdata[evpu_pkg::CTRL_OVR_BIT];
      end
    end
  end

  // Capture pending inputs as override sets
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      store_r <= '0;
    end else if (wr_w && i_paddr == evpu_pkg::ADDR_TEST_CTRL && ovr_ok_w &&
                 i_pwdata[evpu_pkg::CTRL_OVR_BIT] && !override_r) begin
      store_r <= live_w;
    end else if (wr_w && i_paddr == evpu_pkg::ADDR_TEST_WINDOW && test_ok_w) begin
      for (int j = 0; j < 8; j++) begin
        if (grp_mask_w[j] && (int'(group_r) * 8 + j) < evpu_pkg::LIVE_BITS) begin
          store_r[int'(group_r) * 8 + j] <= i_pwdata[j];
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      promo_r <= evpu_pkg::PROMO_RST[7:1];
    end else if (wr_w && i_paddr == evpu_pkg::ADDR_PROMO_SEL && i_cpu.i_mask) begin
      promo_r <= i_pwdata[7:1];
    end
  end

  assign src_w  = override_r ? store_r : live_w;
  // IRQ source always present, whatever the vector count
  assign mask_w = (i_cpu.i_mask ? 122'h0 : ~122'h0) & src_w[121:0] &
                  (((I_VECTORS >= 122) ? ~122'h0 : ((122'h1 << I_VECTORS) - 122'h1)) |
                   (122'h1 << evpu_pkg::IDX_IRQ));

  assign promo_idx_w = ({promo_r, 1'b0} <= evpu_pkg::PROMO_MAX && int'(promo_r) < I_VECTORS) ?
                       promo_r : evpu_pkg::IDX_IRQ;

  // Tick source moves into vacated slot
  always_comb begin
    perm_w = mask_w;
    if (promo_idx_w != RTI_IDX) begin
      perm_w[promo_idx_w] = mask_w[RTI_IDX];
      perm_w[RTI_IDX]     = 1'b0;
    end
  end

  evpu_prio_pick #(
    .WIDTH (122),
    .IW    (7)
  ) u_pick (
    .i_req (perm_w),
    .o_any (pick_any_w),
    .o_idx (pick_idx_w)
  );

  always_comb begin
    if (mask_w[promo_idx_w]) begin
      win_idx_w = promo_idx_w;
    end else if (pick_idx_w == promo_idx_w) begin
      win_idx_w = RTI_IDX;
    end else begin
      win_idx_w = pick_idx_w;
    end
  end

  always_comb begin
    any_w     = 1'b1;
    cur_vec_w = vec_of(win_idx_w);
    if (i_exc.sys_reset) begin
      cur_vec_w = evpu_pkg::VEC_SYS_RESET;
    end else if (i_exc.clk_mon_reset) begin
      cur_vec_w = evpu_pkg::VEC_CLK_MON;
    end else if (i_exc.watchdog_reset) begin
      cur_vec_w = evpu_pkg::VEC_WATCHDOG;
    end else if (i_exc.trap) begin
      cur_vec_w = evpu_pkg::VEC_TRAP;
    end else if (i_exc.software_interrupt) begin
      cur_vec_w = evpu_pkg::VEC_SWI;
    end else if (src_w[evpu_pkg::IDX_HIGH_PRIORITY_PIN_REQUEST] && !i_cpu.x_mask) begin
      cur_vec_w = evpu_pkg::VEC_HIGH_PRIORITY_PIN_REQUEST;
    end else if (!pick_any_w && !mask_w[promo_idx_w]) begin
      any_w = 1'b0;
    end
  end

  // Reset value is software interrupt vector
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      last_vec_r <= evpu_pkg::VEC_SWI;
      seen_r     <= 1'b0;
    end else if (any_w) begin
      last_vec_r <= cur_vec_w;
      seen_r     <= 1'b1;
    end
  end

  // Vector frozen while CPU requests it
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_vec_addr    <= evpu_pkg::VEC_SWI;
      o_int_pending <= 1'b0;
    end else begin
      o_int_pending <= any_w;
      if (!i_vec_req) begin
        o_vec_addr <= any_w ? cur_vec_w : last_vec_r;
      end
    end
  end

  // Wake on enabled request or pin request
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wakeup <= 1'b0;
    end else begin
      o_wakeup <= any_w || i_exc.high_priority_pin_request;
    end
  end

  a_ovr_write_gate: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (wr_w && i_paddr == evpu_pkg::ADDR_TEST_CTRL && !ovr_ok_w) |=> $stable(override_r))
    else $error("override bit changed without permission");
  a_test_wr_block: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (wr_w && i_paddr == evpu_pkg::ADDR_TEST_WINDOW && !test_ok_w) |=> $stable(store_r))
    else $error("test register written while blocked");
  a_normal_read_zero: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (setup_w && !i_pwrite && i_paddr == evpu_pkg::ADDR_TEST_WINDOW && !i_cpu.special_mode) |=>
    (o_pready && o_prdata == 32'h0000_0000))
    else $error("test read not zero in normal mode");
  a_top_group_high: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (setup_w && !i_pwrite && i_paddr == evpu_pkg::ADDR_TEST_WINDOW && group_r == evpu_pkg::GROUP_TOP) |=>
    (o_prdata[7:3] == 5'b00000))
    else $error("top group upper bits not zero");
  a_promo_gate: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (wr_w && i_paddr == evpu_pkg::ADDR_PROMO_SEL && !i_cpu.i_mask) |=> $stable(promo_r))
    else $error("promotion written without I mask");
  a_reset_vector: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (!i_vec_req && i_exc.sys_reset) |=> (o_vec_addr == evpu_pkg::VEC_SYS_RESET))
    else $error("system reset vector wrong");
  a_vec_hold: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_vec_req && $past(i_vec_req)) |-> $stable(o_vec_addr))
    else $error("vector moved during request");
  a_swi_default: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (!seen_r && !any_w && !i_vec_req) |=> (o_vec_addr == evpu_pkg::VEC_SWI))
    else $error("default vector is not software interrupt");
  a_wake_pin: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_exc.high_priority_pin_request |=> o_wakeup)
    else $error("no wake on pin request");
  a_ovr_capture: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    $rose(override_r) |-> (store_r == $past(live_w)))
    else $error("pending inputs not captured");

  // End-to-end vector, pending, wake and bus checks
  a_promo_first: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (!i_vec_req && mask_w[promo_idx_w] && i_exc[5:1] == 5'h00 && !(src_w[evpu_pkg::IDX_HIGH_PRIORITY_PIN_REQUEST] && !i_cpu.x_mask)) |=>
    (o_vec_addr == (evpu_pkg::VEC_BASE | {8'h00, $past(promo_idx_w), 1'b0})))
    else $error("promoted request did not win");
  a_high_priority_pin_request_vector: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (!i_vec_req && i_exc[5:1] == 5'h00 && src_w[evpu_pkg::IDX_HIGH_PRIORITY_PIN_REQUEST] && !i_cpu.x_mask) |=>
    (o_vec_addr == evpu_pkg::VEC_HIGH_PRIORITY_PIN_REQUEST))
    else $error("pin request vector wrong");
  a_trap_vector: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (!i_vec_req && i_exc[5:3] == 3'h0 && i_exc.trap) |=> (o_vec_addr == evpu_pkg::VEC_TRAP))
    else $error("trap vector wrong");
  a_pending_level: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    any_w |=> o_int_pending)
    else $error("pending flag missing");
  a_masked_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_cpu.i_mask && i_cpu.x_mask && i_exc[5:1] == 5'h00) |=> !o_int_pending)
    else $error("masked request shown as pending");
  a_wake_valid: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    any_w |=> o_wakeup)
    else $error("no wake on valid request");
  a_pready_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    o_pslverr |-> o_pready)
    else $error("error without ready");
  a_rd_upper_zero: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    o_pready |-> (o_prdata[31:8] == 24'h00_0000))
    else $error("read data upper bits not zero");
endmodule
`default_nettype wire

// ### tb/evpu_src_model.sv
// Peripheral request sources that keep each request up until told to drop it
`timescale 1ns/10ps
`default_nettype none
module evpu_src_model (
  input  wire logic         i_ref_clk,
  input  wire logic         i_reset_n,
  input  wire logic [121:0] i_raise,
  input  wire logic [121:0] i_drop,
  output logic      [121:0] o_irq_lines
);
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq_lines <= '0;
    end else begin
      o_irq_lines <= (o_irq_lines | i_raise) & ~i_drop;
    end
  end
endmodule
`default_nettype wire

// ### tb/evpu_tb_top.sv
// Self-checking bench for the exception vector priority unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module evpu_tb_top;
  logic                i_ref_clk;
  logic                i_reset_n;
  logic                i_psel;
  logic                i_penable;
  logic                i_pwrite;
  logic [7:0]          i_paddr;
  logic [31:0]         i_pwdata;
  logic [31:0]         o_prdata;
  logic                o_pready;
  logic                o_pslverr;
  logic [121:0]        irq_lines;
  logic [121:0]        raise;
  logic [121:0]        drop;
  evpu_pkg::evpu_exc_t i_exc;
  evpu_pkg::evpu_cpu_t i_cpu;
  logic                i_vec_req;
  logic [15:0]         o_vec_addr;
  logic                o_int_pending;
  logic                o_wakeup;
  logic [31:0]         q;
  logic                e;
  int                  bad_count = 0;
  int                  n_checks = 0;
  localparam logic [7:0]  CT = evpu_pkg::ADDR_TEST_CTRL;
  localparam logic [7:0]  WN = evpu_pkg::ADDR_TEST_WINDOW;
  localparam logic [7:0]  PR = evpu_pkg::ADDR_PROMO_SEL;
  localparam logic [15:0] VT [6] = '{evpu_pkg::VEC_SYS_RESET, evpu_pkg::VEC_CLK_MON, evpu_pkg::VEC_WATCHDOG,
                                    evpu_pkg::VEC_TRAP, evpu_pkg::VEC_SWI, evpu_pkg::VEC_HIGH_PRIORITY_PIN_REQUEST};

  evpu_top #(.I_VECTORS(64), .RTI_IDX(7'h3C)) u_dut (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_irq_lines(irq_lines), .i_exc(i_exc),
    .i_cpu(i_cpu), .i_vec_req(i_vec_req), .o_vec_addr(o_vec_addr),
    .o_int_pending(o_int_pending), .o_wakeup(o_wakeup)
  );

  evpu_src_model u_src (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_raise(raise), .i_drop(drop), .o_irq_lines(irq_lines)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_ref_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 20);
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (k >= 20) begin
      bad_count++;
      $display("[ERR] pready exp 1 got timeout");
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic er);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("prdata", ex, q)
    `CHK("pslverr", er, e)
  endtask

  task automatic setc(input logic [2:0] c);
    @(posedge i_ref_clk);
    i_cpu <= evpu_pkg::evpu_cpu_t'(c);
  endtask

  task automatic lines(input logic [121:0] up, input logic [121:0] dn);
    @(posedge i_ref_clk);
    raise <= up;
    drop <= dn;
    @(posedge i_ref_clk);
    raise <= '0;
    drop <= '0;
  endtask

  task automatic vchk(input logic [15:0] ex);
    repeat (2) @(posedge i_ref_clk);
    i_vec_req <= 1'b1;
    @(posedge i_ref_clk);
    `CHK("vector", ex, o_vec_addr)
    @(posedge i_ref_clk);
    `CHK("vector held", ex, o_vec_addr)
    i_vec_req <= 1'b0;
  endtask

  function automatic logic [121:0] ln(input int k);
    return 122'h1 << k;
  endfunction

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    bad_count++;
    $display("[ERR] run exp done got timeout");
    give_verdict();
  end

  initial begin
    {i_reset_n, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_vec_req} = '0;
    {raise, drop, i_exc, i_cpu} = '0;
    repeat (8) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    vchk(16'hFFF6);
    rd(CT, 8'h00, 1'b0);
    rd(PR, 8'hF2, 1'b0);
    rd(8'h00, 8'h00, 1'b1);
    wr(CT, 8'h13);
    rd(CT, 8'h03, 1'b0);
    rd(WN, 8'h00, 1'b0);
    lines(ln(121) | ln(0), '0);
    for (int j = 0; j < 6; j++) begin
      @(posedge i_ref_clk);
      i_exc <= evpu_pkg::evpu_exc_t'(6'h3F >> j);
      vchk(VT[j]);
    end
    i_exc <= '0;
    vchk(16'hFFF2);
    lines('0, ln(0));
    vchk(16'hFFF2);
    lines(ln(0), ln(121));
    vchk(16'hFF00);
    lines('0, ln(0));
    vchk(16'hFF00);
    setc(3'b010);
    wr(PR, 8'h10);
    setc(3'b000);
    wr(PR, 8'h20);
    rd(PR, 8'h10, 1'b0);
    lines(ln(8) | ln(50), '0);
    vchk(16'hFF10);
    `CHK("pending", 1'b1, o_int_pending)
    lines(ln(60), ln(8));
    vchk(16'hFF64);
    setc(3'b010);
    wr(PR, 8'h80);
    setc(3'b000);
    lines(ln(8), ln(60));
    vchk(16'hFF64);
    @(posedge i_ref_clk);
    i_exc <= evpu_pkg::evpu_exc_t'(6'h04);
    vchk(evpu_pkg::VEC_TRAP);
    setc(3'b011);
    i_exc <= evpu_pkg::evpu_exc_t'(6'h01);
    repeat (3) @(posedge i_ref_clk);
    `CHK("wakeup", 1'b1, o_wakeup)
    `CHK("pending", 1'b0, o_int_pending)
    i_exc <= '0;
    lines(ln(3), ln(8) | ln(50));
    `CHK("wakeup", 1'b0, o_wakeup)
    setc(3'b111);
    wr(CT, 8'h10);
    rd(CT, 8'h10, 1'b0);
    rd(WN, 8'h08, 1'b0);
    lines('0, ln(3));
    rd(WN, 8'h08, 1'b0);
    wr(WN, 8'h81);
    rd(WN, 8'h81, 1'b0);
    wr(CT, 8'h1F);
    wr(WN, 8'hFF);
    rd(WN, 8'h07, 1'b0);
    wr(CT, 8'h19);
    wr(WN, 8'hFF);
    rd(WN, 8'h00, 1'b0);
    wr(CT, 8'h10);
    setc(3'b101);
    wr(WN, 8'h02);
    rd(WN, 8'h81, 1'b0);
    vchk(16'hFFF2);
    setc(3'b000);
    rd(WN, 8'h00, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
